/* File: design/ccts_top.sv */
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module ccts_top
    import ccts_pkg::*;
(
    input  wire logic             clk_sys,          // System clock, 250 MHz
    input  wire logic             reset,            // Synchronous reset, active high
    input  wire logic [4:0]       avs_address,      // Byte address
    input  wire logic             avs_read,         // Read request
    input  wire logic             avs_write,        // Write request
    input  wire logic [31:0]      avs_writedata,    // Write data
    input  wire logic [3:0]       avs_byteenable,   // Byte lanes
    output logic [31:0]           avs_readdata,     // Read data
    output logic                  avs_waitrequest,  // Stall while answer pending
    output logic                  irq,              // Level interrupt
    input  wire logic [N_IN-1:0]  clamp_raw,        // Per-input clamp from analog
    input  wire logic             com_clamp_raw,    // Common clamp from analog
    input  wire logic             reg_cfg_mode,     // Register configuration mode
    input  wire logic             seq_active,       // Standard or advanced sequencer on
    input  wire logic             seq_valid,        // Sequencer asks for a conversion
    input  wire logic [2:0]       seq_chan,         // Channel asked by sequencer
    input  wire logic             seq_last,         // Asked channel ends the sequence
    input  wire logic             cmd_mode,         // Either command mode on
    input  wire logic             cmd_frame,        // Pulse at start of a serial frame
    input  wire logic             cmd_sck_rise,     // Pulse on a serial clock rising edge
    input  wire logic             cmd_sdi,          // Serial input sampled at that edge
    input  wire logic             cfg_highz,        // Configured high-Z of the channel
    input  wire logic [2:0]       cfg_osr,          // Configured oversampling ratio
    input  wire logic             cfg_unipolar,     // Configured polarity of the channel
    input  wire logic             conv_done,        // Converter finished a result
    input  wire logic [15:0]      conv_data,        // Converter result code
    input  wire logic             conv_thresh,      // Threshold detector hit
    output logic                  conv_start,       // Start pulse to converter
    output ccts_conv_t            conv_cfg,         // Settings for the started conversion
    output logic                  clamp_current_select,  // Zero selects reduced current
    output logic [2:0]            ref_range,        // Reference range setting
    output logic                  overvoltage_or_alert_flag  // Alert bit for results
);

    // Behaviour notes for whoever picks this up next

    // Clamp levels come from analog comparators

    // They are not tied to our clock at all

    // Two flops settle them before any use

    // So live bits lag the pins by two cycles

    // The summary flag is sticky on purpose

    // Software may poll it long after a short event

    // A read clears it only with all per-input clamps quiet

    // A clamp still live at that read wins

    // The common input has a live bit only

    // It takes no part in the summary flag

    // Its rising edge does raise an event though

    // The alert flag travels with each result

    // It is captured at the converter's done strobe

    // Per-input clamp bits always feed it, the common bit does not

    // The threshold hit joins only when enabled

    // Sensor results never carry a threshold hit

    // Sensor starts ignore the channel settings

    // High-Z is forced on and the ratio is one

    // Coding is unipolar, ground on the minus side

    // The sequencer owns the converter first

    // A command code is dropped if both ask at once

    // The sensor slot follows the sequence end

    // It is dropped if the sequencer stops

    // Command codes are five bits, MSB first

    // Codes above the inputs start nothing, except the sensor code

    // A frame pulse restarts the code count

    // Bits after the fifth are ignored

    // Every bus access costs one wait cycle

    // Read data is loaded in that wait cycle

    // It then stands when the master takes it

    // Writes land one edge after the wait, when the master takes the answer

    // Only byte lane zero carries writable bits

    // Unmapped reads answer zero

    // Unmapped writes are dropped silently

    // Range codes past the last option are dropped

    // The host must still match the real reference

    // A wrong range only costs accuracy

    // Interrupt status bits are write one to clear

    // A new event in the clear cycle wins

    // Nothing is lost at the price of a re-read

    // The interrupt line is a plain level

    // It stays high while a masked-in bit is set

    // Current select resets to zero

    // Zero keeps the reduced current mode on

    // Whole state of the block
    typedef struct packed {
        logic [N_IN:0]   sync1;      // First synchroniser stage
        logic [N_IN:0]   sync2;      // Second stage, the live clamp bits
        logic            sticky;     // Summary clamp flag
        logic            com_prev;   // Common clamp one cycle ago
        logic [IRQ_W-1:0] irq_st;    // Interrupt status
        logic [IRQ_W-1:0] irq_msk;   // Interrupt mask
        logic            cur_sel;    // Clamp current select
        logic            alt_thr;    // Alert includes threshold indicator
        logic            tmp_en;     // Temperature sample enable
        logic [2:0]      ref_rng;    // Reference range
        logic            ack;        // Bus answer cycle
        logic [31:0]     rdata;      // Read data
        logic            tmp_pend;   // Temperature slot owed to sequence
        logic [2:0]      bitcnt;     // Code bits taken this frame
        logic [4:0]      code;       // Code shift register
        logic            start;      // Conversion start pulse
        ccts_conv_t      cfg;        // Settings of current conversion
        logic [15:0]     res;        // Last result
        logic            res_alt;    // Alert flag of last result
        logic            res_tmp;    // Last result from sensor
    } ccts_state_t;

    ccts_state_t st_ff;              // Registered state
    ccts_state_t nxt_st;             // Next state
    logic        any_clamp;          // Any input clamp live
    logic        alert_now;          // Alert flag as it stands now
    logic        rd_go;              // Read taken this cycle
    logic        wr_go;              // Write taken this cycle
    logic [31:0] clamp_word;         // Clamp register image
    logic [IRQ_W-1:0] evt;           // Events this cycle
    logic [4:0]  code_next;          // Code including the current bit
    ccts_conv_t  chan_cfg;           // Settings for an analog input
    ccts_conv_t  temp_cfg;           // Settings for the sensor

    // Clamp summary and alert; threshold indicator only for analog inputs
    assign any_clamp = |st_ff.sync2[N_IN-1:0];
    assign alert_now = any_clamp | (st_ff.alt_thr & conv_thresh
                                    & ~st_ff.cfg.pos_temp);

    // Bus request is taken on the second cycle, so every access waits once
    assign rd_go = avs_read & st_ff.ack;
    assign wr_go = avs_write & st_ff.ack;
    assign avs_waitrequest = (avs_read | avs_write) & ~st_ff.ack;

    // Clamp bits are visible at any time, configuration mode included
    assign clamp_word = {22'h0, st_ff.sticky, st_ff.sync2};

    // Analog input settings as configured
    always_comb begin
        chan_cfg            = '0;
        chan_cfg.chan       = seq_valid ? seq_chan : code_next[2:0];
        chan_cfg.highz      = cfg_highz;
        chan_cfg.oversampling_ratio        = cfg_osr;
        chan_cfg.unipolar   = cfg_unipolar;
        chan_cfg.thresh_en  = 1'b1;
    end

    // Sensor settings override configuration
    always_comb begin
        temp_cfg            = '0;
        temp_cfg.pos_temp   = 1'b1;
        temp_cfg.neg_reference_ground_pin = 1'b1;
        temp_cfg.highz      = 1'b1;
        temp_cfg.oversampling_ratio        = OSR_ONE;
        temp_cfg.unipolar   = 1'b1;
        temp_cfg.thresh_en  = 1'b0;
    end

    assign code_next = {st_ff.code[3:0], cmd_sdi};

    // Next state
    always_comb begin
        nxt_st = st_ff;
        evt    = '0;

        // Two-flop crossing of asynchronous clamp levels
        nxt_st.sync1 = {com_clamp_raw, clamp_raw};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.com_prev = st_ff.sync2[N_IN];

        // Read of the clamp register while idle clears the summary
        if (rd_go && avs_address == OFS_CLAMP && !any_clamp) begin
            nxt_st.sticky = 1'b0;
        end
        // Any live clamp keeps it set, winning over the clear
        if (any_clamp) begin
            nxt_st.sticky = 1'b1;
        end
        evt[IRQ_SUM] = any_clamp & ~st_ff.sticky;
        evt[IRQ_COM] = st_ff.sync2[N_IN] & ~st_ff.com_prev;

        // Bus answer cycle toggles off after each taken request
        nxt_st.ack = (avs_read | avs_write) & ~st_ff.ack;

        // Read data mux, loaded in the wait cycle; unmapped reads answer zero
        if (avs_read && !st_ff.ack) begin
            case (avs_address)
                OFS_CLAMP:   nxt_st.rdata = clamp_word;
                OFS_CTRL:    nxt_st.rdata = {26'h0, st_ff.ref_rng, st_ff.tmp_en,
                                             st_ff.alt_thr, st_ff.cur_sel};
                OFS_IRQ_ST:  nxt_st.rdata = {29'h0, st_ff.irq_st};
                OFS_IRQ_MSK: nxt_st.rdata = {29'h0, st_ff.irq_msk};
                OFS_RESULT:  nxt_st.rdata = {14'h0, st_ff.res_tmp, st_ff.res_alt,
                                             st_ff.res};
                default:     nxt_st.rdata = 32'h0;
            endcase
        end

        // Register writes, low byte lane holds every writable bit
        if (wr_go && avs_byteenable[0]) begin
            case (avs_address)
                OFS_CTRL: begin
                    nxt_st.cur_sel = avs_writedata[CTL_CUR_BIT];
                    nxt_st.alt_thr = avs_writedata[CTL_ALT_BIT];
                    nxt_st.tmp_en  = avs_writedata[CTL_TMP_BIT];
                    // Host must match the applied reference; bad codes are dropped
                    if (avs_writedata[CTL_REF_LSB+:3] <= REF_RNG_MAX) begin
                        nxt_st.ref_rng = avs_writedata[CTL_REF_LSB+:3];
                    end
                end
                OFS_IRQ_MSK: nxt_st.irq_msk = avs_writedata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        // Conversion selection, one start per cycle at most
        nxt_st.start = 1'b0;
        if (seq_active && seq_valid) begin
            nxt_st.start = 1'b1;
            nxt_st.cfg   = chan_cfg;
            if (seq_last && st_ff.tmp_en) begin
                nxt_st.tmp_pend = 1'b1;
            end
        end else if (seq_active && st_ff.tmp_pend) begin
            nxt_st.start    = 1'b1;
            nxt_st.cfg      = temp_cfg;
            nxt_st.tmp_pend = 1'b0;
        end
        if (!seq_active) begin
            nxt_st.tmp_pend = 1'b0;
        end

        // Command modes take a five-bit code, MSB first
        if (cmd_mode && cmd_frame) begin
            nxt_st.bitcnt = 3'h0;
            nxt_st.code   = 5'h0;
        end else if (cmd_mode && cmd_sck_rise && st_ff.bitcnt < CMD_BITS) begin
            nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
            nxt_st.code   = code_next;
            if (st_ff.bitcnt == CMD_BITS - 3'h1 && !nxt_st.start) begin
                if (code_next == TEMP_CODE) begin
                    nxt_st.start = 1'b1;
                    nxt_st.cfg   = temp_cfg;
                end else if (code_next < 5'(N_IN)) begin
                    nxt_st.start = 1'b1;
                    nxt_st.cfg   = chan_cfg;
                end
            end
        end

        // Capture result with its alert flag
        if (conv_done) begin
            nxt_st.res     = conv_data;
            nxt_st.res_alt = alert_now;
            nxt_st.res_tmp = st_ff.cfg.pos_temp;
            evt[IRQ_CONV]  = 1'b1;
        end

        // Sticky events; a new event beats a write-one clear
        nxt_st.irq_st = st_ff.irq_st;
        if (wr_go && avs_address == OFS_IRQ_ST && avs_byteenable[0]) begin
            nxt_st.irq_st = st_ff.irq_st & ~avs_writedata[IRQ_W-1:0];
        end
        nxt_st.irq_st = nxt_st.irq_st | evt;
    end

    // State register with synchronous reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_ff         <= '0;
            st_ff.cur_sel <= RST_CUR_SEL;
            st_ff.alt_thr <= RST_ALT_THR;
            st_ff.tmp_en  <= RST_TMP_EN;
            st_ff.ref_rng <= RST_REF_RNG;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from state
    assign avs_readdata              = st_ff.rdata;
    assign irq                       = |(st_ff.irq_st & st_ff.irq_msk);
    assign conv_start                = st_ff.start;
    assign conv_cfg                  = st_ff.cfg;
    assign clamp_current_select      = st_ff.cur_sel;
    assign ref_range                 = st_ff.ref_rng;
    assign overvoltage_or_alert_flag = st_ff.res_alt;

endmodule

/* File: design/ccts_pkg.sv */
package ccts_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] OFS_CLAMP   = 5'h00;   // Live clamp bits and summary flag
    localparam logic [4:0] OFS_CTRL    = 5'h04;   // Control bits
    localparam logic [4:0] OFS_IRQ_ST  = 5'h08;   // Interrupt status, write one to clear
    localparam logic [4:0] OFS_IRQ_MSK = 5'h0C;   // Interrupt mask
    localparam logic [4:0] OFS_RESULT  = 5'h10;   // Last conversion result

    // Clamp register fields
    localparam int CLP_IN_LSB  = 0;               // Eight per-input live bits
    localparam int CLP_COM_BIT = 8;               // Common input live bit
    localparam int CLP_SUM_BIT = 9;               // Sticky summary bit

    // Control register fields
    localparam int CTL_CUR_BIT = 0;               // Clamp current select
    localparam int CTL_ALT_BIT = 1;               // Alert includes threshold indicator
    localparam int CTL_TMP_BIT = 2;               // Temperature sample enable
    localparam int CTL_REF_LSB = 3;               // Reference range, three bits

    // Result register fields
    localparam int RES_ALT_BIT = 16;              // Alert flag delivered with result
    localparam int RES_TMP_BIT = 17;              // Result came from temperature channel

    // Interrupt event bits
    localparam int IRQ_SUM  = 0;                  // Summary clamp flag rose
    localparam int IRQ_COM  = 1;                  // Common clamp became active
    localparam int IRQ_CONV = 2;                  // Conversion result captured
    localparam int IRQ_W    = 3;                  // Number of events

    // Values after reset
    localparam logic       RST_CUR_SEL = 1'b0;    // Reduced current mode on
    localparam logic       RST_ALT_THR = 1'b0;    // Alert is clamp bits only
    localparam logic       RST_TMP_EN  = 1'b0;    // No temperature slot
    localparam logic [2:0] RST_REF_RNG = 3'h0;    // Lowest reference range
    localparam logic [2:0] REF_RNG_MAX = 3'h4;    // Five range options, 0 to 4

    // Channel selection constants
    localparam int         N_IN      = 8;         // Analog inputs
    localparam logic [4:0] TEMP_CODE = 5'h0F;     // Command code of temperature sensor
    localparam logic [2:0] CMD_BITS  = 3'h5;      // Rising edges carrying the code
    localparam logic [2:0] OSR_ONE   = 3'h0;      // Ratio code meaning no oversampling

    // Settings handed to the converter with each start
    typedef struct packed {
        logic [2:0] chan;        // Analog input number
        logic       pos_temp;    // Positive input takes the sensor
        logic       neg_reference_ground_pin;  // Negative input takes reference ground
        logic       highz;       // Input high-impedance mode
        logic [2:0] oversampling_ratio;         // Oversampling ratio code
        logic       unipolar;    // Unipolar transfer coding
        logic       thresh_en;   // Threshold detection allowed
    } ccts_conv_t;

endpackage

/* File: verification/ccts_chk.sv */
`timescale 1ns/1ps
module ccts_chk
    import ccts_pkg::*;
(
    input wire logic            clk_sys,                  // Clock
    input wire logic            reset,                    // Reset
    input wire logic            avs_read,                 // Read
    input wire logic            avs_write,                // Write
    input wire logic            avs_waitrequest,          // Stall
    input wire logic [N_IN-1:0] clamp_raw,                // Clamps
    input wire logic            seq_active,               // Sequencer on
    input wire logic            seq_valid,                // Sequencer ask
    input wire logic [2:0]      seq_chan,                 // Asked channel
    input wire logic            conv_done,                // Result strobe
    input wire logic            conv_thresh,              // Threshold hit
    input wire logic            conv_start,               // Start pulse
    input wire ccts_conv_t      conv_cfg,                 // Start settings
    input wire logic            clamp_current_select,     // Current select
    input wire logic [2:0]      ref_range,                // Range
    input wire logic            overvoltage_or_alert_flag // Alert
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Four steady cycles, so the two-flop synchroniser has surely caught up
    sequence clamps_on; (|clamp_raw)[*4]; endsequence
    sequence clamps_off; (!(|clamp_raw))[*4]; endsequence
    bus_wait_a: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    seq_start_a: assert property (
        seq_valid && seq_active |=> conv_start && conv_cfg.chan == $past(seq_chan))
        else $error("sequencer start missing or wrong channel");
    temp_mode_a: assert property (
        conv_start && conv_cfg.pos_temp |-> conv_cfg.highz && conv_cfg.oversampling_ratio == OSR_ONE)
        else $error("temperature start without forced high-Z and ratio one");
    temp_route_a: assert property (
        conv_start && conv_cfg.pos_temp |-> conv_cfg.neg_reference_ground_pin && conv_cfg.unipolar
            && !conv_cfg.thresh_en)
        else $error("temperature start with wrong routing or coding");
    alert_on_a: assert property (
        clamps_on ##0 conv_done |=> overvoltage_or_alert_flag)
        else $error("alert flag low while clamps active");
    alert_off_a: assert property (
        clamps_off ##0 (conv_done && !conv_thresh) |=> !overvoltage_or_alert_flag)
        else $error("alert flag high with no cause");
    range_max_a: assert property (ref_range <= REF_RNG_MAX)
        else $error("reference range beyond last option");
    cur_reset_a: assert property (
        $fell(reset) |-> !clamp_current_select && ref_range == RST_REF_RNG)
        else $error("control outputs not at reset values");
endmodule
bind ccts_top ccts_chk i_ccts_chk (.clk_sys, .reset, .avs_read, .avs_write, .avs_waitrequest,
    .clamp_raw, .seq_active, .seq_valid, .seq_chan, .conv_done, .conv_thresh, .conv_start,
    .conv_cfg, .clamp_current_select, .ref_range, .overvoltage_or_alert_flag);

/* File: verification/ccts_host_mdl.sv */
`timescale 1ns/1ps
// Host side of a command frame: five edges, code shifted out MSB first
module ccts_host_mdl (
    input  wire logic       clk_sys,      // Clock
    input  wire logic       reset,        // Reset
    input  wire logic       go,           // Start a frame
    input  wire logic       slow,         // Idle cycle before each edge
    input  wire logic [4:0] code,         // Code to send
    output logic            cmd_frame,    // Frame start pulse
    output logic            cmd_sck_rise, // Rising edge pulse
    output logic            cmd_sdi,      // Serial data
    output logic            busy          // Frame in progress
);
    logic [4:0] sh_ff;  // Bits left
    logic [2:0] cnt_ff; // Edges left
    logic       gap_ff; // Idle before next edge
    // Outside frames the data line toggles so a stale bit is never mistaken for data
    always_ff @(posedge clk_sys) begin
        cmd_frame <= 1'b0;
        cmd_sck_rise <= 1'b0;
        if (reset) begin
            busy <= 1'b0;
            cmd_sdi <= 1'b0;
        end else if (go && !busy) begin
            {busy, cmd_frame, sh_ff, cnt_ff, gap_ff} <= {2'b11, code, 3'h5, slow};
        end else if (!busy) begin
            cmd_sdi <= ~cmd_sdi;
        end else if (cnt_ff == 3'h0) begin
            busy <= 1'b0;
        end else if (gap_ff) begin
            gap_ff <= 1'b0;
        end else begin
            {cmd_sck_rise, cmd_sdi, sh_ff} <= {1'b1, sh_ff, 1'b0};
            {cnt_ff, gap_ff} <= {cnt_ff - 3'h1, slow};
        end
    end
endmodule

/* File: verification/clamp_status_and_temp_channel_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module clamp_status_and_temp_channel_test
    import ccts_pkg::*;
();
    logic            clk_sys = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, go = 1'b0;
    logic [4:0]      avs_address = 5'h00, code = 5'h00;  // Bus address, command code
    logic [31:0]     avs_writedata = 32'h0, avs_readdata, rd; // Bus data, last read
    logic [N_IN-1:0] clamp_raw = 8'h00, cv;             // Input clamps
    logic            com_clamp_raw = 1'b0, seq_active = 1'b0, seq_valid = 1'b0, seq_last = 1'b0;
    logic            cmd_mode = 1'b0, cfg_highz = 1'b0, cfg_unipolar = 1'b0, conv_done = 1'b0;
    logic            conv_thresh = 1'b0, slow = 1'b0, hbusy, cmd_frame, cmd_sck_rise, cmd_sdi;
    logic            avs_waitrequest, irq, conv_start, clamp_current_select, overvoltage_or_alert_flag;
    logic [2:0]      seq_chan = 3'h0, cfg_osr = 3'h0, ref_range;
    logic [15:0]     conv_data = 16'h0000;
    ccts_conv_t      conv_cfg, seen;                   // Settings of the last start seen
    int              err_total = 0, cmp_count = 0, m_ctrl = 0, found = 0, v;
    ccts_top i_ccts_top (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .irq, .clamp_raw, .com_clamp_raw,
        .reg_cfg_mode(1'b1), .seq_active, .seq_valid, .seq_chan, .seq_last, .cmd_mode, .cmd_frame,
        .cmd_sck_rise, .cmd_sdi, .cfg_highz, .cfg_osr, .cfg_unipolar, .conv_done, .conv_data,
        .conv_thresh, .conv_start, .conv_cfg, .clamp_current_select, .ref_range,
        .overvoltage_or_alert_flag);
    ccts_host_mdl i_ccts_host_mdl (.clk_sys, .reset, .go, .slow, .code, .cmd_frame,
        .cmd_sck_rise, .cmd_sdi, .busy(hbusy));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // Bus cycle: request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
        if (n >= 50) err_total++;
        @(posedge clk_sys);
    endtask
    // Bounded look for a start pulse; found stays 0 if none came
    task automatic wait_start();
        found = 0;
        for (int i = 0; i < 30 && found == 0; i++) begin
            @(negedge clk_sys);
            if (conv_start === 1'b1) begin
                found = 1;
                seen = conv_cfg;
            end
        end
    endtask
    // One result from the converter, then the stored word against the model
    task automatic convert(input logic [15:0] d, input logic t, input logic tmp);
        @(posedge clk_sys);
        {conv_done, conv_data, conv_thresh} <= {1'b1, d, t};
        @(posedge clk_sys);
        {conv_done, conv_thresh} <= 2'b00;
        bus(1'b0, OFS_RESULT, 32'h0);
        `CHK(rd, {14'h0, tmp, (|clamp_raw) | (t & m_ctrl[CTL_ALT_BIT] & !tmp), d})
        `CHK(overvoltage_or_alert_flag, rd[RES_ALT_BIT])
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h973A));
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, 5'h14, 32'h0);
        `CHK(rd, 32'h0)
        // Every range code; codes above the last option must leave the field alone
        for (int r = 0; r < 8; r++) begin
            v = (r > 4) ? (m_ctrl & 7) : ($urandom & 7);
            bus(1'b1, OFS_CTRL, 32'((r << 3) | v));
            if (r <= 4) m_ctrl = (r << 3) | v;
            bus(1'b0, OFS_CTRL, 32'h0);
            `CHK(rd, 32'(m_ctrl))
            `CHK({ref_range, clamp_current_select}, {m_ctrl[5:3], m_ctrl[0]})
        end
        bus(1'b1, OFS_CTRL, 32'h0);
        m_ctrl = 0;
        bus(1'b1, OFS_IRQ_ST, 32'h7);
        cv = 8'($urandom) | 8'h01;
        {clamp_raw, com_clamp_raw} <= {cv, 1'b1};
        repeat (4) @(posedge clk_sys);
        bus(1'b0, OFS_CLAMP, 32'h0);
        `CHK(rd, {22'h0, 2'b11, cv})
        bus(1'b0, OFS_CLAMP, 32'h0);
        `CHK(rd[CLP_SUM_BIT], 1'b1)
        bus(1'b0, OFS_IRQ_ST, 32'h0);
        `CHK({rd, irq}, {32'h3, 1'b0})
        bus(1'b1, OFS_IRQ_MSK, 32'h1);
        `CHK(irq, 1'b1)
        convert(16'($urandom), 1'b0, 1'b0);
        bus(1'b1, OFS_IRQ_ST, 32'h1);
        `CHK(irq, 1'b0)
        {clamp_raw, com_clamp_raw} <= 9'h000;
        repeat (4) @(posedge clk_sys);
        bus(1'b0, OFS_CLAMP, 32'h0);
        `CHK(rd, 32'h200)
        bus(1'b0, OFS_CLAMP, 32'h0);
        `CHK(rd, 32'h0)
        convert(16'($urandom), 1'b1, 1'b0);
        bus(1'b1, OFS_CTRL, 32'h6);
        m_ctrl = 6;
        convert(16'($urandom), 1'b1, 1'b0);
        // Mid-sequence, then sequence end, with temperature slot on; configured settings must be overridden
        for (int k = 0; k < 2; k++) begin
            {cfg_osr, seq_chan} <= {3'h1 + 3'($urandom % 7), 3'($urandom)};
            {seq_active, seq_valid, seq_last} <= {2'b11, k[0]};
            @(posedge clk_sys);
            {seq_valid, seq_last} <= 2'b00;
            wait_start();
            `CHK({found, seen.pos_temp}, {32'h1, 1'b0})
            wait_start();
            `CHK(found, k)
            if (found == 1) `CHK({seen.pos_temp, seen.highz, seen.oversampling_ratio}, {2'b11, OSR_ONE})
            @(posedge clk_sys);
        end
        seq_active <= 1'b0;
        convert(16'($urandom), 1'b1, 1'b1);
        // Command codes: temperature, two inputs, one with no channel
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 32'(TEMP_CODE) : (k == 3) ? 32'h10 : ($urandom & 7);
            {cmd_mode, code, slow, go} <= {1'b1, v[4:0], k[0], 1'b1};
            @(posedge clk_sys);
            go <= 1'b0;
            wait_start();
            `CHK(found, int'(v < 16))
            if (found == 1) `CHK({seen.pos_temp, seen.chan}, {v == 15, v[2:0] & {3{v != 15}}})
            @(posedge clk_sys);
        end
        complete_run();
    end
endmodule
